/* File: core/plb_latency_top.sv */
`timescale 1ns/1ps
module plb_latency_top #(
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic [1:0]    speed_sel,
   input  wire logic [1:0]    tx_depth,
   input  wire logic [1:0]    rx_depth,
   input  wire logic          xover_loopback,
   input  wire logic [2:0]    path_sel,
   input  wire logic [DW-1:0] quad_serial_rx_in_data,
   input  wire logic          quad_serial_rx_in_valid,
   input  wire logic          quad_serial_rx_in_sop,
   input  wire logic          quad_serial_rx_in_eop,
   input  wire logic [DW-1:0] single_serial_rx_in_data,
   input  wire logic          single_serial_rx_in_valid,
   input  wire logic          single_serial_rx_in_sop,
   input  wire logic          single_serial_rx_in_eop,
   input  wire logic [DW-1:0] copper_rx_data,
   input  wire logic [3:0]    copper_rx_pair_valid,
   input  wire logic          copper_rx_sop,
   input  wire logic          copper_rx_eop,
   input  wire logic          copper_rx_dribble,
   output logic [DW-1:0]      copper_tx_data,
   output logic               copper_tx_valid,
   output logic               copper_tx_sop,
   output logic               copper_tx_eop,
   output logic [DW-1:0]      single_serial_tx_out_data,
   output logic               single_serial_tx_out_valid,
   output logic               single_serial_tx_out_sop,
   output logic               single_serial_tx_out_eop,
   output logic [DW-1:0]      quad_serial_tx_out_data,
   output logic               quad_serial_tx_out_valid,
   output logic               quad_serial_tx_out_sop,
   output logic               quad_serial_tx_out_eop,
   output logic               source_ready,
   output logic               path_refused,
   output logic               overflow
);
   localparam int SW = plb_pkg::STAMP_W;
   localparam int PW = plb_pkg::PAIRS;
   // word layout in the buffer: path, eop, sop, data, due time
   localparam int FW = 3 + 2 + DW + SW;
   localparam int IW = 2 + 2 + 2 + 1 + 3 + 2 * (DW + 3) + DW + PW + 3;

   // ---------------------------------------------------------------
   // input synchroniser
   // ---------------------------------------------------------------
   // every pin is double flopped; nothing reads the first stage
   logic [IW-1:0] sync1_reg;
   logic [IW-1:0] sync2_reg;
   wire  [IW-1:0] pins_in = {
      speed_sel, tx_depth, rx_depth, xover_loopback, path_sel,
      quad_serial_rx_in_data, quad_serial_rx_in_valid,
      quad_serial_rx_in_sop, quad_serial_rx_in_eop,
      single_serial_rx_in_data, single_serial_rx_in_valid,
      single_serial_rx_in_sop, single_serial_rx_in_eop,
      copper_rx_data, copper_rx_pair_valid,
      copper_rx_sop, copper_rx_eop, copper_rx_dribble};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pins_in;
         sync2_reg <= sync1_reg;
      end
   end

   wire [1:0]    spd_s;
   wire [1:0]    txd_s;
   wire [1:0]    rxd_s;
   wire          lpbk_s;
   wire [2:0]    path_s;
   wire [DW-1:0] q_data_s;
   wire          q_valid_s;
   wire          q_sop_s;
   wire          q_eop_s;
   wire [DW-1:0] s_data_s;
   wire          s_valid_s;
   wire          s_sop_s;
   wire          s_eop_s;
   wire [DW-1:0] cu_data_s;
   wire [PW-1:0] cu_pv_s;
   wire          cu_sop_s;
   wire          cu_eop_s;
   wire          cu_drib_s;

   assign {spd_s, txd_s, rxd_s, lpbk_s, path_s,
           q_data_s, q_valid_s, q_sop_s, q_eop_s,
           s_data_s, s_valid_s, s_sop_s, s_eop_s,
           cu_data_s, cu_pv_s, cu_sop_s, cu_eop_s,
           cu_drib_s} = sync2_reg;

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   // wraps; due times stay within half the range so sign of age works
   logic [SW-1:0] now_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) now_reg <= '0;
      else          now_reg <= now_reg + 1'b1;
   end

   // ---------------------------------------------------------------
   // copper pair deskew
   // ---------------------------------------------------------------
   // at 1000 a word counts only once all four pairs have delivered
   logic [PW-1:0] pair_seen_reg;
   logic [PW-1:0] pair_seen_next;
   wire  [PW-1:0] pairs_now = pair_seen_reg | cu_pv_s;
   wire           is_gig    = (spd_s == plb_pkg::PLB_SPD_1000);
   wire           cu_word   = is_gig ? (&pairs_now) : cu_pv_s[0];

   always_comb begin
      pair_seen_next = pair_seen_reg;
      if (!is_gig || (&pairs_now)) begin
         pair_seen_next = '0;
      end else begin
         pair_seen_next = pairs_now;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) pair_seen_reg <= '0;
      else          pair_seen_reg <= pair_seen_next;
   end

   // ---------------------------------------------------------------
   // source selection
   // ---------------------------------------------------------------
   wire from_quad = (path_s == plb_pkg::PLB_P_Q2CU) ||
                    (path_s == plb_pkg::PLB_P_Q2S);
   wire from_sgl  = (path_s == plb_pkg::PLB_P_S2Q) ||
                    (path_s == plb_pkg::PLB_P_S2S);
   wire from_cu   = (path_s == plb_pkg::PLB_P_CU2S);
   // single to single only exists with crossover loopback
   wire refuse    = ((path_s == plb_pkg::PLB_P_S2S) && !lpbk_s) ||
                    !(from_quad || from_sgl || from_cu);

   // dribble words never enter the buffer, so the frame shortens
   wire cu_keep = cu_word && !cu_drib_s;

   wire          src_valid = !refuse &&
                             ((from_quad && q_valid_s) ||
                              (from_sgl  && s_valid_s) ||
                              (from_cu   && cu_keep));
   wire [DW-1:0] src_data  = from_quad ? q_data_s :
                             from_sgl  ? s_data_s : cu_data_s;
   wire          src_sop   = from_quad ? q_sop_s :
                             from_sgl  ? s_sop_s : cu_sop_s;
   wire          src_eop   = from_quad ? q_eop_s :
                             from_sgl  ? s_eop_s : cu_eop_s;

   // ---------------------------------------------------------------
   // due time of each word
   // ---------------------------------------------------------------
   // depth steps are added as buffer residence time
   wire [SW-1:0] lat_cyc = plb_pkg::plb_lat_cyc(path_s,
                                                spd_s, lpbk_s,
                                                txd_s, rxd_s);
   wire [SW-1:0] due_in  = now_reg + lat_cyc;
   wire [FW-1:0] fifo_in = {path_s, src_eop, src_sop, src_data, due_in};

   // ---------------------------------------------------------------
   // elastic buffer
   // ---------------------------------------------------------------
   wire          fifo_in_ready;
   wire          fifo_out_valid;
   wire [FW-1:0] fifo_out;
   wire          head_due;

   plb_fifo #(
      .WIDTH (FW),
      .DEPTH (plb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (src_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (head_due),
      .out_data  (fifo_out)
   );

   wire [2:0]    head_path = fifo_out[FW-1 -: 3];
   wire          head_eop  = fifo_out[DW+SW+1];
   wire          head_sop  = fifo_out[DW+SW];
   wire [DW-1:0] head_data = fifo_out[SW +: DW];
   wire [SW-1:0] head_due_t = fifo_out[SW-1:0];
   wire [SW-1:0] head_age  = now_reg - head_due_t;
   // the drain stalls until the head word has aged; the buffer fills
   assign head_due = fifo_out_valid && !head_age[SW-1];

   // ---------------------------------------------------------------
   // destination routing
   // ---------------------------------------------------------------
   wire to_cu   = head_due && (head_path == plb_pkg::PLB_P_Q2CU);
   wire to_quad = head_due && (head_path == plb_pkg::PLB_P_S2Q);
   wire to_sgl  = head_due && ((head_path == plb_pkg::PLB_P_Q2S) ||
                               (head_path == plb_pkg::PLB_P_S2S) ||
                               (head_path == plb_pkg::PLB_P_CU2S));

   // limitation: ready reaches the pins one cycle late, plus the
   // synchroniser, so a word landing on a full buffer is lost
   wire lost = src_valid && !fifo_in_ready;

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         copper_tx_valid <= 1'b0;
         copper_tx_sop   <= 1'b0;
         copper_tx_eop   <= 1'b0;
         copper_tx_data  <= '0;
      end else begin
         copper_tx_valid <= to_cu;
         copper_tx_sop   <= to_cu && head_sop;
         copper_tx_eop   <= to_cu && head_eop;
         if (to_cu) copper_tx_data <= head_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         single_serial_tx_out_valid <= 1'b0;
         single_serial_tx_out_sop   <= 1'b0;
         single_serial_tx_out_eop   <= 1'b0;
         single_serial_tx_out_data  <= '0;
      end else begin
         single_serial_tx_out_valid <= to_sgl;
         single_serial_tx_out_sop   <= to_sgl && head_sop;
         single_serial_tx_out_eop   <= to_sgl && head_eop;
         if (to_sgl) single_serial_tx_out_data <= head_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         quad_serial_tx_out_valid <= 1'b0;
         quad_serial_tx_out_sop   <= 1'b0;
         quad_serial_tx_out_eop   <= 1'b0;
         quad_serial_tx_out_data  <= '0;
      end else begin
         quad_serial_tx_out_valid <= to_quad;
         quad_serial_tx_out_sop   <= to_quad && head_sop;
         quad_serial_tx_out_eop   <= to_quad && head_eop;
         if (to_quad) quad_serial_tx_out_data <= head_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         source_ready <= 1'b0;
         path_refused <= 1'b0;
         overflow     <= 1'b0;
      end else begin
         source_ready <= fifo_in_ready;
         path_refused <= refuse;
         overflow     <= lost;
      end
   end

endmodule : plb_latency_top

/* File: core/plb_pkg.sv */
// How it works
// - quad serial to copper at 1000: start and end 222 to 250 ns later
// - quad serial to copper at 100: start and end 506 to 614 ns
// - quad serial to copper at 10: start and end 3827 to 4644 ns
// - transmit depth 00 is minimum; steps add 8, 40 or 400 ns
// - quad to single serial: 156-232, 520-700, 4212-5472 ns
// - single to quad serial: 164-224, 472-636, 3804-5048 ns
// - loopback single to single serial: 252-336, 876-1172, 7548-10008 ns
// - loopback latencies only while crossover loopback bit is one
// - loopback copper to single serial: 404-484, 1048-1300, 8577-10583 ns
// - receive depth 00 is minimum; steps add speed-based time
// - at 1000 copper timing starts from the last of four pairs
// - copper receive drops dribble bits, so latency varies; here a dribble word is dropped whole and the latency stays fixed
package plb_pkg;

   // ---------------------------------------------------------------
   // clock and steps
   // ---------------------------------------------------------------
   localparam int CLK_NS        = 100;
   localparam int STEP_1000_NS  = 8;
   localparam int STEP_100_NS   = 40;
   localparam int STEP_10_NS    = 400;
   localparam int STAMP_W       = 8;
   localparam int FIFO_DEPTH    = 16;
   localparam int PAIRS         = 4;

   // ---------------------------------------------------------------
   // latency windows in ns
   // ---------------------------------------------------------------
   localparam int Q2CU_1000_MIN = 222;
   localparam int Q2CU_1000_MAX = 250;
   localparam int Q2CU_100_MIN  = 506;
   localparam int Q2CU_100_MAX  = 614;
   localparam int Q2CU_10_MIN   = 3827;
   localparam int Q2CU_10_MAX   = 4644;
   localparam int Q2S_1000_MIN  = 156;
   localparam int Q2S_1000_MAX  = 232;
   localparam int Q2S_100_MIN   = 520;
   localparam int Q2S_100_MAX   = 700;
   localparam int Q2S_10_MIN    = 4212;
   localparam int Q2S_10_MAX    = 5472;
   localparam int S2Q_1000_MIN  = 164;
   localparam int S2Q_1000_MAX  = 224;
   localparam int S2Q_100_MIN   = 472;
   localparam int S2Q_100_MAX   = 636;
   localparam int S2Q_10_MIN    = 3804;
   localparam int S2Q_10_MAX    = 5048;
   localparam int S2S_1000_MIN  = 252;
   localparam int S2S_1000_MAX  = 336;
   localparam int S2S_100_MIN   = 876;
   localparam int S2S_100_MAX   = 1172;
   localparam int S2S_10_MIN    = 7548;
   localparam int S2S_10_MAX    = 10008;
   localparam int CU2S_1000_MIN = 292;
   localparam int CU2S_100_MIN  = 620;
   localparam int CU2S_10_MIN   = 4817;
   localparam int CU2SL_1000_MIN = 404;
   localparam int CU2SL_1000_MAX = 484;
   localparam int CU2SL_100_MIN  = 1048;
   localparam int CU2SL_100_MAX  = 1300;
   localparam int CU2SL_10_MIN   = 8577;
   localparam int CU2SL_10_MAX   = 10583;

   // ---------------------------------------------------------------
   // modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PLB_SPD_10   = 2'b00,
      PLB_SPD_100  = 2'b01,
      PLB_SPD_1000 = 2'b10
   } plb_speed_e;

   typedef enum logic [2:0] {
      PLB_P_Q2CU = 3'b000,
      PLB_P_Q2S  = 3'b001,
      PLB_P_S2Q  = 3'b010,
      PLB_P_S2S  = 3'b011,
      PLB_P_CU2S = 3'b100
   } plb_path_e;

   // ---------------------------------------------------------------
   // latency in whole cycles, least time rounded up
   // ---------------------------------------------------------------
   function automatic logic [STAMP_W-1:0] plb_lat_cyc(
      input logic [2:0] path,
      input logic [1:0] spd,
      input logic       lpbk,
      input logic [1:0] txd,
      input logic [1:0] rxd);
      int base;
      int step;
      int depth;
      int cyc;
      base  = 0;
      step  = STEP_10_NS;
      depth = int'(txd);
      case (spd)
         PLB_SPD_1000: step = STEP_1000_NS;
         PLB_SPD_100:  step = STEP_100_NS;
         default:      step = STEP_10_NS;
      endcase
      case (path)
         PLB_P_Q2CU: base = (spd == PLB_SPD_1000) ? Q2CU_1000_MIN :
                            (spd == PLB_SPD_100)  ? Q2CU_100_MIN :
                                                    Q2CU_10_MIN;
         PLB_P_Q2S:  base = (spd == PLB_SPD_1000) ? Q2S_1000_MIN :
                            (spd == PLB_SPD_100)  ? Q2S_100_MIN :
                                                    Q2S_10_MIN;
         PLB_P_S2Q:  base = (spd == PLB_SPD_1000) ? S2Q_1000_MIN :
                            (spd == PLB_SPD_100)  ? S2Q_100_MIN :
                                                    S2Q_10_MIN;
         PLB_P_S2S:  base = (spd == PLB_SPD_1000) ? S2S_1000_MIN :
                            (spd == PLB_SPD_100)  ? S2S_100_MIN :
                                                    S2S_10_MIN;
         PLB_P_CU2S: begin
            depth = int'(rxd);
            if (lpbk) begin
               base = (spd == PLB_SPD_1000) ? CU2SL_1000_MIN :
                      (spd == PLB_SPD_100)  ? CU2SL_100_MIN :
                                              CU2SL_10_MIN;
            end else begin
               base = (spd == PLB_SPD_1000) ? CU2S_1000_MIN :
                      (spd == PLB_SPD_100)  ? CU2S_100_MIN :
                                              CU2S_10_MIN;
            end
         end
         default: base = 0;
      endcase
      cyc = (base + depth * step + CLK_NS - 1) / CLK_NS;
      if (cyc < 1) begin
         cyc = 1;
      end
      return cyc[STAMP_W-1:0];
   endfunction : plb_lat_cyc

endpackage : plb_pkg

/* File: core/plb_fifo.sv */
`timescale 1ns/1ps
module plb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // ---------------------------------------------------------------
   // flags
   // ---------------------------------------------------------------
   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop)      count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule : plb_fifo

/* File: bench/plb_latency_top_asserts.sv */
`timescale 1ns/1ps
module plb_latency_top_asserts (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [2:0] path_sel,
   input wire logic       xover_loopback,
   input wire logic       path_refused,
   input wire logic       source_ready,
   input wire logic       copper_tx_valid,
   input wire logic       copper_tx_sop,
   input wire logic       copper_tx_eop,
   input wire logic       single_serial_tx_out_valid,
   input wire logic       single_serial_tx_out_sop,
   input wire logic       single_serial_tx_out_eop,
   input wire logic       quad_serial_tx_out_valid,
   input wire logic       quad_serial_tx_out_sop,
   input wire logic       quad_serial_tx_out_eop
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // path selection
   // ---------------------------------------------------------------
   // five cycles cover both sync flops and the output register
   sequence s_bad_code;
      (path_sel > 3'h4) [*5];
   endsequence
   sequence s_lpbk(logic on);
      (path_sel == 3'h3 && xover_loopback == on) [*5];
   endsequence
   bad_code_a: assert property (s_bad_code |-> path_refused)
      else $error("undefined path accepted");
   lpbk_off_a: assert property (s_lpbk(1'b0) |-> path_refused)
      else $error("loop path taken without loopback");
   lpbk_on_a: assert property (s_lpbk(1'b1) |-> !path_refused)
      else $error("loop path refused under loopback");

   // ---------------------------------------------------------------
   // after reset and output framing
   // ---------------------------------------------------------------
   // no word can get through sync and the shortest latency this fast
   sequence s_quiet;
      (!copper_tx_valid && !single_serial_tx_out_valid &&
       !quad_serial_tx_out_valid) [*5];
   endsequence
   reset_quiet_a: assert property ($rose(reset_n) |-> s_quiet)
      else $error("output word too soon after reset");
   ready_up_a: assert property ($rose(reset_n) |-> ##[0:2] source_ready)
      else $error("buffer not ready after reset");
   cu_sop_a: assert property (copper_tx_sop |-> copper_tx_valid)
      else $error("copper start without word");
   cu_eop_a: assert property (copper_tx_eop |-> copper_tx_valid)
      else $error("copper end without word");
   ss_mark_a: assert property ((single_serial_tx_out_sop ||
      single_serial_tx_out_eop) |-> single_serial_tx_out_valid)
      else $error("single serial marker without word");
   qs_mark_a: assert property ((quad_serial_tx_out_sop ||
      quad_serial_tx_out_eop) |-> quad_serial_tx_out_valid)
      else $error("quad serial marker without word");
endmodule : plb_latency_top_asserts

bind plb_latency_top plb_latency_top_asserts u_chk (
   .clk(clk), .reset_n(reset_n), .path_sel(path_sel),
   .xover_loopback(xover_loopback), .path_refused(path_refused),
   .source_ready(source_ready), .copper_tx_valid(copper_tx_valid),
   .copper_tx_sop(copper_tx_sop), .copper_tx_eop(copper_tx_eop),
   .single_serial_tx_out_valid(single_serial_tx_out_valid),
   .single_serial_tx_out_sop(single_serial_tx_out_sop),
   .single_serial_tx_out_eop(single_serial_tx_out_eop),
   .quad_serial_tx_out_valid(quad_serial_tx_out_valid),
   .quad_serial_tx_out_sop(quad_serial_tx_out_sop),
   .quad_serial_tx_out_eop(quad_serial_tx_out_eop)
);

/* File: bench/plb_mac_model.sv */
`timescale 1ns/1ps
module plb_mac_model (
   input  wire logic clk,
   output logic [7:0] data,
   output logic       valid,
   output logic       sop,
   output logic       eop
);
   initial begin
      data = 8'h00;
      valid = 1'b0;
      sop = 1'b0;
      eop = 1'b0;
   end

   // idle data is inverted so a stale word is never mistaken for a live one
   task automatic burst(input logic [7:0] b, input int n);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         data <= b + 8'(i);
         valid <= 1'b1;
         sop <= (i == 0);
         eop <= (i == n - 1);
         @(posedge clk);
      end
      data <= ~(b + 8'(n - 1));
      valid <= 1'b0;
      sop <= 1'b0;
      eop <= 1'b0;
   endtask : burst
endmodule : plb_mac_model

/* File: bench/plb_latency_top_tb.sv */
`timescale 1ns/1ps
module plb_latency_top_tb;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [1:0]  speed_sel = 2'h2;
   logic [1:0]  tx_depth = 2'h0;
   logic [1:0]  rx_depth = 2'h0;
   logic        lpbk = 1'b0;
   logic [2:0]  path_sel = 3'h0;
   logic [7:0]  cu_d = 8'h00;
   logic [3:0]  cu_pv = 4'h0;
   logic        cu_sop = 1'b0;
   logic        cu_eop = 1'b0;
   logic        cu_drib = 1'b0;
   wire  [7:0]  q_d, s_d, ct_d, st_d, qt_d;
   wire         q_v, q_s, q_e, s_v, s_s, s_e;
   wire         ct_v, ct_s, ct_e, st_v, st_s, st_e, qt_v, qt_s, qt_e;
   wire         rdy, refused, ovf;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          ovf_n = 0;
   logic        ready_lo = 1'b0;
   logic [7:0]  rnd = 8'h12;
   logic [11:0] obs[$];
   int          obs_t[$];

   always #50 clk = ~clk;

   plb_latency_top dut (
      .clk(clk), .reset_n(reset_n), .speed_sel(speed_sel),
      .tx_depth(tx_depth), .rx_depth(rx_depth), .xover_loopback(lpbk),
      .path_sel(path_sel), .quad_serial_rx_in_data(q_d),
      .quad_serial_rx_in_valid(q_v), .quad_serial_rx_in_sop(q_s),
      .quad_serial_rx_in_eop(q_e), .single_serial_rx_in_data(s_d),
      .single_serial_rx_in_valid(s_v), .single_serial_rx_in_sop(s_s),
      .single_serial_rx_in_eop(s_e), .copper_rx_data(cu_d),
      .copper_rx_pair_valid(cu_pv), .copper_rx_sop(cu_sop),
      .copper_rx_eop(cu_eop), .copper_rx_dribble(cu_drib),
      .copper_tx_data(ct_d), .copper_tx_valid(ct_v),
      .copper_tx_sop(ct_s), .copper_tx_eop(ct_e),
      .single_serial_tx_out_data(st_d), .single_serial_tx_out_valid(st_v),
      .single_serial_tx_out_sop(st_s), .single_serial_tx_out_eop(st_e),
      .quad_serial_tx_out_data(qt_d), .quad_serial_tx_out_valid(qt_v),
      .quad_serial_tx_out_sop(qt_s), .quad_serial_tx_out_eop(qt_e),
      .source_ready(rdy), .path_refused(refused), .overflow(ovf));
   plb_mac_model qm (.clk(clk), .data(q_d), .valid(q_v), .sop(q_s),
      .eop(q_e));
   plb_mac_model sm (.clk(clk), .data(s_d), .valid(s_v), .sop(s_s),
      .eop(s_e));

   // ---------------------------------------------------------------
   // output monitor: port code, sop, eop, data and arrival cycle
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ct_v === 1'b1) obs.push_back({2'h0, ct_s, ct_e, ct_d});
      if (ct_v === 1'b1) obs_t.push_back(cyc);
      if (st_v === 1'b1) obs.push_back({2'h1, st_s, st_e, st_d});
      if (st_v === 1'b1) obs_t.push_back(cyc);
      if (qt_v === 1'b1) obs.push_back({2'h2, qt_s, qt_e, qt_d});
      if (qt_v === 1'b1) obs_t.push_back(cyc);
      if (ovf === 1'b1) ovf_n <= ovf_n + 1;
      if (reset_n && rdy === 1'b0) ready_lo <= 1'b1;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // cycles of latency: least time of the path rounded up
   function automatic int exp_lat(input int row, input int s, input int d);
      int base[6][3] = '{'{3827, 506, 222}, '{4212, 520, 156},
         '{3804, 472, 164}, '{7548, 876, 252}, '{8577, 1048, 404},
         '{4817, 620, 292}};
      int step[3] = '{400, 40, 8};
      return (base[row][s] + d * step[s] + 99) / 100;
   endfunction : exp_lat

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] expv);
      comparisons++;
      if (seen !== expv) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, expv, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task automatic setup(input logic [2:0] p, input logic [1:0] s,
                        input logic lb, input logic [1:0] d);
      @(posedge clk);
      path_sel <= p;
      speed_sel <= s;
      lpbk <= lb;
      tx_depth <= d;
      rx_depth <= ~d;
      repeat (6) @(posedge clk);
      obs.delete();
      obs_t.delete();
   endtask : setup

   // pairs arrive last-first so pair 0 completes the word at every speed
   task automatic cu_word(input logic [7:0] w, input logic dr);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {cu_d, cu_sop, cu_eop, cu_drib} <= {w, 2'b11, dr};
         cu_pv <= 4'h8 >> i;
      end
      @(posedge clk);
      {cu_d, cu_pv, cu_sop, cu_eop, cu_drib} <= {~w, 7'h00};
   endtask : cu_word

   task automatic wait_obs(input int n);
      for (int k = 0; k < 200 && obs.size() < n; k++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : wait_obs

   task automatic xfer(input int row, input logic [1:0] s, input logic lb);
      logic [2:0] p;
      logic [1:0] d;
      logic [7:0] w;
      int ts;
      p = (row == 5) ? 3'h4 : 3'(row);
      rnd = lfsr(rnd);
      d = rnd[1:0];
      w = lfsr(rnd);
      rnd = w;
      setup(p, s, lb, d);
      if (p < 3'h2) qm.burst(w, 1);
      else if (p == 3'h4) cu_word(w, 1'b0);
      else sm.burst(w, 1);
      ts = cyc - 1;
      wait_obs(1);
      check("word count", obs.size(), 1);
      if (obs.size() > 0) begin
         check("port", obs[0][11:10], (p == 3'h0) ? 2'h0 :
               (p == 3'h2) ? 2'h2 : 2'h1);
         check("word", obs[0][9:0], {2'b11, w});
         check("latency", obs_t[0] - ts,
               exp_lat(row, int'(s), (p == 3'h4) ? 3 - int'(d) : int'(d)) + 4);
      end
   endtask : xfer

   initial begin
      #2000000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      // every path at every speed, random depth and data
      for (int r = 0; r < 6; r++) begin
         for (int s = 0; s < 3; s++) begin
            xfer(r, 2'(s), (r == 3 || r == 4) || (rnd[2] && r < 5));
         end
      end
      $display("test latency sweep done");
      // loop path without loopback and an undefined code are refused
      setup(3'h3, 2'h2, 1'b0, 2'h0);
      check("refused", refused, 1'b1);
      sm.burst(8'h5a, 1);
      wait_obs(1);
      check("refused words", obs.size(), 0);
      setup(3'h6, 2'h2, 1'b0, 2'h0);
      check("bad code", refused, 1'b1);
      $display("test refusal done");
      // a dribble word leaves nothing behind
      setup(3'h4, 2'h0, 1'b0, 2'h0);
      cu_word(8'h3c, 1'b1);
      wait_obs(1);
      check("dribble words", obs.size(), 0);
      $display("test dribble done");
      // twenty words back to back overrun the buffer
      setup(3'h1, 2'h0, 1'b0, 2'h3);
      ready_lo <= 1'b0;
      ovf_n <= 0;
      qm.burst(8'hf8, 20);
      wait_obs(16);
      check("stored words", obs.size(), 16);
      check("lost words", ovf_n, 4);
      check("ready dropped", ready_lo, 1'b1);
      check("ready again", rdy, 1'b1);
      for (int i = 0; i < obs.size(); i++) begin
         check("burst order", obs[i][7:0], 8'(8'hf8 + i));
      end
      $display("test overflow done");
      print_verdict();
   end
endmodule : plb_latency_top_tb
